// *** rtl/dbg_ctrl_map.svh ***
// register offsets, field positions, codes and reset values of the debug control port
`ifndef DBG_CTRL_MAP_SVH
`define DBG_CTRL_MAP_SVH
`define CAP_SOFT_RESET_OFS    8'h00
`define CAP_ERASE_TRIG_OFS    8'h04
`define CAP_ERASE_STATE_OFS   8'h08
`define CAP_PROT_STATE_OFS    8'h0C
`define CAP_IDENTITY_OFS      8'hFC
`define CAP_SOFT_RESET_RST    1'b0
`define PROT_FIELD_DISABLED   8'hFF
`define PROT_FIELD_ENABLED    8'h00
`define DP_ADDR_IDCODE        2'h0
`define DP_ADDR_CTRL_STAT     2'h1
`define DP_ADDR_SELECT        2'h2
`define DP_ADDR_RDBUFF        2'h3
`define DP_PWR_REQ_BIT        28
`define DP_PWR_ACK_BIT        29
`define DP_SEL_APSEL_LSB      24
`define DP_SEL_BANK_LSB       4
`define APSEL_CPU_MEM         8'h00
`define APSEL_CONTROL         8'h01
`define ACK_OK                3'h1
`define ACK_WAIT              3'h2
`define ACK_FAULT             3'h4
`define REQ_BITS              4'h8
`define ACK_BITS              6'h03
`define DATA_BITS             6'h20
`define DP_IDCODE_VAL         32'h1357_9BDF // arbitrary value
`define ID_REVISION_VAL       4'h1          // arbitrary value
`define ID_CONT_VAL           4'h5          // arbitrary value
`define ID_MAKER_VAL          7'h2A         // arbitrary value
`define ID_CLASS_VAL          4'h0
`define ID_PORT_VAL           8'h02         // arbitrary value
`endif

// *** rtl/dbg_ctrl_pkg.sv ***
// types shared by the debug control access port
package dbg_ctrl_pkg;
	typedef enum logic [2:0] {
		ST_IDLE, ST_REQ, ST_TRN1, ST_ACK, ST_RDATA, ST_TRN2, ST_WDATA
	} link_state_type;

	typedef struct packed {
		logic       park;
		logic       stop;
		logic       parity;
		logic [1:0] addr;
		logic       rnw;
		logic       ap;
		logic       start;
	} link_request_type;

	typedef struct packed {
		logic [3:0] revision;
		logic [3:0] maker_continuation_field;
		logic [6:0] maker_identity_field;
		logic [3:0] port_class;
		logic [4:0] reserved;
		logic [7:0] port_identifier_field;
	} identity_type;
endpackage

// *** rtl/debug_control_access_port.sv ***
// serial debug port slave with the control access port registers
`timescale 1ns/1ps
`include "dbg_ctrl_map.svh"

module debug_control_access_port (
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic       ce,
	input  wire logic       debug_clock_pin,
	input  wire logic       swdio_in,
	output logic            swdio_out,
	output logic            swdio_oe_n,
	input  wire logic [7:0] protect_all_field,
	input  wire logic       erase_done,
	input  wire logic       system_off,
	output logic            soft_reset,
	output logic            erase_start,
	output logic            debug_mode,
	output logic            wake_request,
	output logic            debug_wake_flag_set,
	output logic            cpu_port_access
);
	localparam dbg_ctrl_pkg::identity_type IDENTITY = '{
		revision:                 `ID_REVISION_VAL, // arbitrary value
		maker_continuation_field: `ID_CONT_VAL,     // arbitrary value
		maker_identity_field:     `ID_MAKER_VAL,    // arbitrary value
		port_class:               `ID_CLASS_VAL,
		reserved:                 5'h00,
		port_identifier_field:    `ID_PORT_VAL      // arbitrary value
	};

	logic                         clk_s1_q, clk_s2_q, clk_s3_q;
	logic                         dio_s1_q, dio_s2_q;
	logic                         rise;
	dbg_ctrl_pkg::link_state_type state_q;
	dbg_ctrl_pkg::link_request_type req_q;
	logic [5:0]                   cnt_q;
	logic [2:0]                   ack_q;
	logic [32:0]                  sh_q;
	logic [7:0]                   apsel_q;
	logic [3:0]                   bank_q;
	logic                         pwr_req_q;
	logic                         erase_busy_q;
	logic                         protected_now;
	logic                         req_ok;
	logic [7:0]                   ap_ofs;
	logic [31:0]                  rd_data;
	logic [2:0]                   ack_d;
	logic                         wr_commit;
	dbg_ctrl_pkg::link_request_type req_next;

	// both pins come from the debugger's domain: two flops before any use
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			clk_s1_q <= 1'b0;
			clk_s2_q <= 1'b0;
			clk_s3_q <= 1'b0;
			dio_s1_q <= 1'b1;
			dio_s2_q <= 1'b1;
		end
		else if (ce)
		begin
			clk_s1_q <= debug_clock_pin;
			clk_s2_q <= clk_s1_q;
			clk_s3_q <= clk_s2_q;
			dio_s1_q <= swdio_in;
			dio_s2_q <= dio_s1_q;
		end
	end

	assign rise = ce & clk_s2_q & ~clk_s3_q;

	// anything but the erased pattern counts as protected, the safe reading
	assign protected_now = (protect_all_field != `PROT_FIELD_DISABLED);

	assign req_next = {dio_s2_q, req_q[7:1]};
	assign req_ok   = (req_next.parity == ^{req_next.ap, req_next.rnw, req_next.addr})
	                  & ~req_next.stop & req_next.park;
	assign ap_ofs   = {bank_q, req_next.addr, 2'b00};

	// answer and read data are fixed when the request header completes
	always_comb
	begin
		ack_d   = `ACK_OK;
		rd_data = 32'h0000_0000;
		if (!req_next.ap)
		begin
			case (req_next.addr)
				`DP_ADDR_IDCODE:    rd_data = `DP_IDCODE_VAL; // arbitrary value
				`DP_ADDR_CTRL_STAT: rd_data = {2'b00, pwr_req_q, pwr_req_q, 28'h0000000};
				`DP_ADDR_SELECT:    rd_data = {apsel_q, 16'h0000, bank_q, 4'h0};
				default:            rd_data = 32'h0000_0000;
			endcase
		end
		else if (!pwr_req_q)
			ack_d = `ACK_FAULT;
		else if (apsel_q == `APSEL_CONTROL)
		begin
			// control port stays reachable whatever the protection says
			case (ap_ofs)
				`CAP_SOFT_RESET_OFS:  rd_data = {31'h0, soft_reset};
				`CAP_ERASE_STATE_OFS: rd_data = {31'h0, erase_busy_q};
				`CAP_PROT_STATE_OFS:  rd_data = {31'h0, ~protected_now};
				`CAP_IDENTITY_OFS:    rd_data = IDENTITY;
				default:              rd_data = 32'h0000_0000;
			endcase
		end
		else if (apsel_q == `APSEL_CPU_MEM && protected_now)
			ack_d = `ACK_FAULT;
	end

	// link state machine, one step per debug clock rising edge
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			state_q    <= dbg_ctrl_pkg::ST_IDLE;
			req_q      <= '0;
			cnt_q      <= 6'h00;
			ack_q      <= `ACK_OK;
			sh_q       <= 33'h0_0000_0000;
			swdio_out  <= 1'b1;
			swdio_oe_n <= 1'b1;
		end
		else if (rise)
		begin
			case (state_q)
				dbg_ctrl_pkg::ST_IDLE:
				begin
					req_q <= req_next;
					cnt_q <= 6'h01;
					if (dio_s2_q)
						state_q <= dbg_ctrl_pkg::ST_REQ;
				end
				dbg_ctrl_pkg::ST_REQ:
				begin
					req_q <= req_next;
					cnt_q <= cnt_q + 6'h01;
					if (cnt_q == 6'(`REQ_BITS - 4'h1))
					begin
						// a bad header gets no answer, the debugger times out
						state_q <= req_ok ? dbg_ctrl_pkg::ST_TRN1 : dbg_ctrl_pkg::ST_IDLE;
						ack_q   <= ack_d;
						sh_q    <= {^rd_data, rd_data};
					end
				end
				dbg_ctrl_pkg::ST_TRN1:
				begin
					swdio_oe_n <= 1'b0;
					swdio_out  <= ack_q[0];
					cnt_q      <= 6'h01;
					state_q    <= dbg_ctrl_pkg::ST_ACK;
				end
				dbg_ctrl_pkg::ST_ACK:
				begin
					cnt_q <= cnt_q + 6'h01;
					if (cnt_q != `ACK_BITS)
						swdio_out <= ack_q[cnt_q[1:0]];
					else if (ack_q == `ACK_OK && req_q.rnw)
					begin
						swdio_out <= sh_q[0];
						sh_q      <= {1'b0, sh_q[32:1]};
						cnt_q     <= 6'h01;
						state_q   <= dbg_ctrl_pkg::ST_RDATA;
					end
					else
					begin
						swdio_oe_n <= 1'b1;
						cnt_q      <= 6'h00;
						state_q    <= (ack_q == `ACK_OK) ? dbg_ctrl_pkg::ST_TRN2
						                                  : dbg_ctrl_pkg::ST_IDLE;
					end
				end
				dbg_ctrl_pkg::ST_RDATA:
				begin
					cnt_q <= cnt_q + 6'h01;
					if (cnt_q != `DATA_BITS + 6'h01)
					begin
						swdio_out <= sh_q[0];
						sh_q      <= {1'b0, sh_q[32:1]};
					end
					else
					begin
						swdio_oe_n <= 1'b1;
						state_q    <= dbg_ctrl_pkg::ST_IDLE;
					end
				end
				dbg_ctrl_pkg::ST_TRN2:
					state_q <= dbg_ctrl_pkg::ST_WDATA;
				dbg_ctrl_pkg::ST_WDATA:
				begin
					sh_q  <= {dio_s2_q, sh_q[32:1]};
					cnt_q <= cnt_q + 6'h01;
					if (cnt_q == `DATA_BITS)
						state_q <= dbg_ctrl_pkg::ST_IDLE;
				end
				default:
					state_q <= dbg_ctrl_pkg::ST_IDLE;
			endcase
		end
	end

	// write lands with its parity bit; a parity error drops the write
	assign wr_commit = rise && state_q == dbg_ctrl_pkg::ST_WDATA && cnt_q == `DATA_BITS
	                   && dio_s2_q == ^sh_q[32:1];

	// debug port registers: select and power request
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			apsel_q   <= 8'h00;
			bank_q    <= 4'h0;
			pwr_req_q <= 1'b0;
		end
		else if (wr_commit && !req_q.ap)
		begin
			if (req_q.addr == `DP_ADDR_SELECT)
			begin
				apsel_q <= sh_q[`DP_SEL_APSEL_LSB + 8:`DP_SEL_APSEL_LSB + 1];
				bank_q  <= sh_q[`DP_SEL_BANK_LSB + 4:`DP_SEL_BANK_LSB + 1];
			end
			if (req_q.addr == `DP_ADDR_CTRL_STAT)
				pwr_req_q <= sh_q[`DP_PWR_REQ_BIT + 1];
		end
	end

	// control port writes: soft reset and erase start
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			soft_reset   <= `CAP_SOFT_RESET_RST;
			erase_busy_q <= 1'b0;
			erase_start  <= 1'b0;
		end
		else if (ce)
		begin
			erase_start <= 1'b0;
			if (erase_done)
				erase_busy_q <= 1'b0;
			if (wr_commit && req_q.ap && apsel_q == `APSEL_CONTROL)
			begin
				if ({bank_q, req_q.addr, 2'b00} == `CAP_SOFT_RESET_OFS)
					soft_reset <= sh_q[1];
				// a second trigger during a running erase is ignored
				if ({bank_q, req_q.addr, 2'b00} == `CAP_ERASE_TRIG_OFS
				    && sh_q[1] && !erase_busy_q)
				begin
					erase_busy_q <= 1'b1;
					erase_start  <= 1'b1;
				end
			end
		end
	end

	// mode, wake from system off, and cpu port access strobe
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			debug_mode          <= 1'b0;
			wake_request        <= 1'b0;
			debug_wake_flag_set <= 1'b0;
			cpu_port_access     <= 1'b0;
		end
		else if (ce)
		begin
			debug_mode          <= pwr_req_q;
			wake_request        <= pwr_req_q & ~debug_mode & system_off;
			debug_wake_flag_set <= pwr_req_q & ~debug_mode & system_off;
			cpu_port_access     <= rise && state_q == dbg_ctrl_pkg::ST_TRN1 && req_q.ap
			                       && apsel_q == `APSEL_CPU_MEM && ack_q == `ACK_OK;
		end
	end
endmodule

// *** verif/debug_control_access_port_assertions.sv ***
// concurrent checks on the debug control port pins
`timescale 1ns/1ps
module debug_control_access_port_assertions (
	input wire logic       clk,
	input wire logic       srst,
	input wire logic       ce,
	input wire logic       debug_clock_pin,
	input wire logic       swdio_in,
	input wire logic       swdio_out,
	input wire logic       swdio_oe_n,
	input wire logic [7:0] protect_all_field,
	input wire logic       erase_done,
	input wire logic       system_off,
	input wire logic       soft_reset,
	input wire logic       erase_start,
	input wire logic       debug_mode,
	input wire logic       wake_request,
	input wire logic       debug_wake_flag_set,
	input wire logic       cpu_port_access
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	reset_idle_a: assert property ($fell(srst) |-> swdio_oe_n && !soft_reset && !debug_mode)
		else $error("outputs not idle after reset");
	erase_pulse_a: assert property (erase_start |=> !erase_start)
		else $error("erase start longer than one cycle");
	erase_gate_a: assert property (erase_start |-> debug_mode)
		else $error("erase started outside debug mode");
	soft_gate_a: assert property ($changed(soft_reset) |-> debug_mode)
		else $error("soft reset moved outside debug mode");
	wake_pair_a: assert property (wake_request |-> debug_wake_flag_set && $rose(debug_mode))
		else $error("wake pulse without flag or mode rise");
	wake_cause_a: assert property ($rose(debug_mode) |-> (wake_request == $past(system_off)))
		else $error("wake pulse disagrees with system off");
	mode_write_a: assert property ($changed(debug_mode) |-> $past(swdio_oe_n, 2))
		else $error("debug mode changed while device drove the line");
	drive_bound_a: assert property ($fell(swdio_oe_n) |-> ##[1:400] swdio_oe_n)
		else $error("data line held too long");
	cpu_gate_a: assert property (cpu_port_access |-> debug_mode && protect_all_field == 8'hFF)
		else $error("cpu port access while protected or powered down");
	erase_c: cover property (erase_start);
	wake_c: cover property (wake_request);
	cpu_c: cover property (cpu_port_access);
endmodule

// *** verif/debug_control_access_port_tb_top.sv ***
// bench for the debug control access port
`timescale 1ns/1ps
`include "dbg_ctrl_map.svh"
module debug_control_access_port_tb_top;
	logic        clk, srst, ce, erase_done, system_off, debug_clock_pin, host_out, host_oe_n;
	logic        swdio_out, swdio_oe_n, soft_reset, erase_start, debug_mode;
	logic        wake_request, debug_wake_flag_set, cpu_port_access;
	logic [7:0]  protect_all_field;
	logic [2:0]  ack;
	logic [31:0] rd;
	wire         swdio;
	int          fails, comparisons, n_erase, n_wake, n_cpu, n_flag;
	// released line floats up to the pull-up level
	assign swdio = !swdio_oe_n ? swdio_out : !host_oe_n ? host_out : 1'b1;
	debug_control_access_port DUT (.clk, .srst, .ce, .debug_clock_pin, .swdio_in(swdio),
		.swdio_out, .swdio_oe_n, .protect_all_field, .erase_done, .system_off, .soft_reset,
		.erase_start, .debug_mode, .wake_request, .debug_wake_flag_set, .cpu_port_access);
	swd_host_model host (.link_clk(debug_clock_pin), .host_out, .host_oe_n, .swdio);
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk)
	begin
		n_erase += (erase_start === 1'b1);
		n_wake += (wake_request === 1'b1);
		n_cpu += (cpu_port_access === 1'b1);
		n_flag += (debug_wake_flag_set === 1'b1);
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			fails++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic acc(input logic ap, input logic rnw, input logic [1:0] a,
		input logic [31:0] wd, input logic [2:0] exp_ack);
		host.xfer(ap, rnw, a, wd, ack, rd);
		chk("ack", {29'h0, exp_ack}, {29'h0, ack});
	endtask
	task automatic sel(input logic [7:0] apsel, input logic [3:0] bank);
		acc(1'b0, 1'b0, 2'h2, {apsel, 16'h0, bank, 4'h0}, `ACK_OK);
	endtask
	task automatic rdchk(input logic [7:0] ofs, input logic [31:0] exp);
		sel(`APSEL_CONTROL, ofs[7:4]);
		acc(1'b1, 1'b1, ofs[3:2], 32'h0, `ACK_OK);
		chk("port read", exp, rd);
	endtask
	task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
		sel(`APSEL_CONTROL, ofs[7:4]);
		acc(1'b1, 1'b0, ofs[3:2], d, `ACK_OK);
	endtask
	task automatic end_sim;
		if (fails == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		#4000000;
		fails++;
		end_sim();
	end
	initial
	begin
		srst = 1'b1;
		ce = 1'b1;
		erase_done = 1'b0;
		system_off = 1'b1;
		protect_all_field = `PROT_FIELD_ENABLED;
		repeat (5) @(negedge clk);
		srst = 1'b0;
		repeat (3) @(negedge clk);
		acc(1'b1, 1'b1, 2'h3, 32'h0, `ACK_FAULT);
		acc(1'b0, 1'b1, 2'h0, 32'h0, `ACK_OK);
		chk("dp id", `DP_IDCODE_VAL, rd);
		acc(1'b0, 1'b0, 2'h1, 32'h1000_0000, `ACK_OK);
		chk("debug mode", 32'h1, {31'h0, debug_mode});
		chk("wake pulses", 32'h1, n_wake);
		chk("wake flags", 32'h1, n_flag);
		sel(`APSEL_CPU_MEM, 4'h0);
		acc(1'b1, 1'b1, 2'h0, 32'h0, `ACK_FAULT);
		rdchk(`CAP_PROT_STATE_OFS, 32'h0);
		rdchk(`CAP_SOFT_RESET_OFS, 32'h0);
		wr(`CAP_SOFT_RESET_OFS, 32'h1);
		chk("soft reset", 32'h1, {31'h0, soft_reset});
		rdchk(`CAP_SOFT_RESET_OFS, 32'h1);
		wr(`CAP_SOFT_RESET_OFS, 32'h0);
		chk("soft reset", 32'h0, {31'h0, soft_reset});
		wr(`CAP_ERASE_TRIG_OFS, 32'h0);
		chk("erase starts", 32'h0, n_erase);
		wr(`CAP_ERASE_TRIG_OFS, 32'h1);
		chk("erase starts", 32'h1, n_erase);
		rdchk(`CAP_ERASE_TRIG_OFS, 32'h0);
		rdchk(`CAP_ERASE_STATE_OFS, 32'h1);
		wr(`CAP_ERASE_TRIG_OFS, 32'h1);
		chk("erase starts", 32'h1, n_erase);
		@(negedge clk);
		erase_done = 1'b1;
		protect_all_field = `PROT_FIELD_DISABLED;
		@(negedge clk);
		erase_done = 1'b0;
		rdchk(`CAP_ERASE_STATE_OFS, 32'h0);
		rdchk(`CAP_PROT_STATE_OFS, 32'h1);
		rdchk(`CAP_IDENTITY_OFS, {`ID_REVISION_VAL, `ID_CONT_VAL, `ID_MAKER_VAL,
			`ID_CLASS_VAL, 5'h0, `ID_PORT_VAL});
		sel(`APSEL_CPU_MEM, 4'h0);
		acc(1'b1, 1'b1, 2'h0, 32'h0, `ACK_OK);
		chk("cpu accesses", 32'h1, n_cpu);
		// frozen block ignores a whole frame: released line reads back all ones
		ce = 1'b0;
		acc(1'b0, 1'b0, 2'h1, 32'h0, 3'h7);
		chk("debug mode", 32'h1, {31'h0, debug_mode});
		ce = 1'b1;
		acc(1'b0, 1'b0, 2'h1, 32'h0, `ACK_OK);
		chk("debug mode", 32'h0, {31'h0, debug_mode});
		system_off = 1'b0;
		acc(1'b0, 1'b0, 2'h1, 32'h1000_0000, `ACK_OK);
		chk("debug mode", 32'h1, {31'h0, debug_mode});
		chk("wake pulses", 32'h1, n_wake);
		chk("wake flags", 32'h1, n_flag);
		srst = 1'b1;
		repeat (2) @(negedge clk);
		srst = 1'b0;
		repeat (3) @(negedge clk);
		chk("debug mode", 32'h0, {31'h0, debug_mode});
		acc(1'b1, 1'b1, 2'h0, 32'h0, `ACK_FAULT);
		end_sim();
	end
endmodule
bind debug_control_access_port debug_control_access_port_assertions chk_i (.clk, .srst, .ce,
	.debug_clock_pin, .swdio_in, .swdio_out, .swdio_oe_n, .protect_all_field, .erase_done,
	.system_off, .soft_reset, .erase_start, .debug_mode, .wake_request, .debug_wake_flag_set,
	.cpu_port_access);

// *** verif/swd_host_model.sv ***
// behavioural debugger on the two-wire debug link
`timescale 1ns/1ps
`include "dbg_ctrl_map.svh"
module swd_host_model (
	output logic     link_clk,
	output logic     host_out,
	output logic     host_oe_n,
	input wire logic swdio
);
	initial
	begin
		link_clk = 1'b0;
		host_out = 1'b1;
		host_oe_n = 1'b1;
	end
	// shift on the low phase, sample just before the rise; clock rests low between frames
	task automatic cyc(input logic d, input logic rel, output logic s);
		link_clk = 1'b0;
		host_out = d;
		host_oe_n = rel;
		#400;
		s = swdio;
		link_clk = 1'b1;
		#400;
	endtask
	task automatic xfer(input logic ap, input logic rnw, input logic [1:0] a,
		input logic [31:0] wd, output logic [2:0] ack, output logic [31:0] rd);
		logic [7:0]  h;
		logic [32:0] s;
		logic [32:0] w;
		logic        b;
		h = {1'b1, 1'b0, ^{ap, rnw, a}, a, rnw, ap, 1'b1};
		w = {^wd, wd};
		rd = '0;
		for (int i = 0; i < 8; i++)
			cyc(h[i], 1'b0, b);
		// device drives ack bit 0 from the turnaround rise, the one right after the park bit rise
		for (int i = 8; i < 12; i++)
		begin
			cyc(1'b1, 1'b1, b);
			if (i > 8)
				ack[i - 9] = b;
		end
		if (ack == `ACK_OK && rnw)
		begin
			for (int i = 0; i < 33; i++)
				cyc(1'b1, 1'b1, s[i]);
			// a parity slip spoils the word so the compare catches it
			rd = (s[32] === ^s[31:0]) ? s[31:0] : ~s[31:0];
		end
		if (ack == `ACK_OK && !rnw)
		begin
			cyc(1'b1, 1'b1, b);
			for (int i = 0; i < 33; i++)
				cyc(w[i], 1'b0, b);
		end
		link_clk = 1'b0;
		host_oe_n = 1'b1;
		#800;
	endtask
endmodule
